// *** dcr_consts.svh ***
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define DCR_OFS_ADDR 8'h00
`define DCR_OFS_RST 8'h01
`define DCR_OFS_GCFG 8'h02
`define DCR_OFS_STS 8'h04
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define DCR_ADDR_OVR_BIT 0
`define DCR_RST_KEEP_BIT 0
`define DCR_RST_FULL_BIT 1
`define DCR_RST_ROM_BIT 2
`define DCR_GCFG_PORT_OVR_BIT 7
`define DCR_GCFG_PORT_SEL_BIT 6
`define DCR_GCFG_OUT_OVR_BIT 5
`define DCR_GCFG_RSVD_BIT 4
`define DCR_GCFG_DRIVE_BIT 3
`define DCR_GCFG_IDLE_BIT 2
`define DCR_STS_INIT_BIT 6
// ---------------------------------------------
// reset values and timing
// ---------------------------------------------
`define DCR_GCFG_RST 8'h1C
`define DCR_RST_RST 8'h00
`define DCR_ADDR_DEFAULT 7'h3D
`define DCR_ROM_LOAD_CYC 6'h20
`define DCR_RESET_PULSE_CYC 6'h04
`endif

// *** dcr_pkg.sv ***
package dcr_pkg;
   // register read or write request from the serial slave
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] data;
   } dcr_req_s;
   // pin-level output controls
   typedef struct packed {
      logic portSel;
      logic driveOn;
      logic idleState;
   } dcr_ctl_s;
   typedef enum logic [1:0] {
      DCR_IDLE,
      DCR_LOADING,
      DCR_DONE
   } dcr_load_e;
endpackage

// *** dcr_rom_loader.sv ***
`timescale 1ns/1ps
`include "dcr_consts.svh"
// sequences a configuration load from the fuse rom; done is the init flag
module dcr_rom_loader (
   input wire logic clk, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic start, // one-cycle load request
   output logic busy, // load in progress
   output logic done // initialization complete
);
   dcr_pkg::dcr_load_e state_r;
   dcr_pkg::dcr_load_e state_nxt;
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   // ---------------------------------------------
   // load sequencer
   // ---------------------------------------------
   // a new request restarts the load even while one is running
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         dcr_pkg::DCR_IDLE: begin
            state_nxt = dcr_pkg::DCR_LOADING;
            cnt_nxt = `DCR_ROM_LOAD_CYC;
         end
         dcr_pkg::DCR_LOADING: begin
            cnt_nxt = cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
               state_nxt = dcr_pkg::DCR_DONE;
            end
         end
         dcr_pkg::DCR_DONE: begin
         end
         default: begin
            state_nxt = dcr_pkg::DCR_IDLE;
         end
      endcase
      if (start) begin
         state_nxt = dcr_pkg::DCR_LOADING;
         cnt_nxt = `DCR_ROM_LOAD_CYC;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= dcr_pkg::DCR_IDLE;
         cnt_r <= 6'h00;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         busy <= (state_nxt == dcr_pkg::DCR_LOADING);
         done <= (state_nxt == dcr_pkg::DCR_DONE); // see RQ16
      end
   end
endmodule

// *** dcr_config_regs.sv ***
`timescale 1ns/1ps
`include "dcr_consts.svh"
// How it works
// RQ1: bits 7:1 of register 0 hold the bus address, strapped at startup.
// RQ2: with override 0 the address field ignores writes and reads the strap.
// RQ3: with override 1 the address field is writable and shows the used address.
// RQ4: bit 0 of register 0 picks strap (0) or programmed address (1).
// RQ5: writing 1 to reset bit 2 reloads the rom; bit clears itself.
// RQ6: host polls init-complete flag to learn the reload finished.
// RQ7: writing 1 to reset bit 1 resets all logic and registers; self-clears.
// RQ8: writing 1 to reset bit 0 resets logic but keeps registers; self-clears.
// RQ9: general bit 7 hands port choice to register bit 6.
// RQ10: bit 6 drives port choice under override, else shows the pin.
// RQ11: bit 5 makes drive and idle controls come from register bits.
// RQ12: idle control 1 with drive bit 0 puts outputs in high impedance.
// RQ13: without output override, drive bit reflects the drive pin.
// RQ14: idle control 0 forces high-speed zero while link lock is low.
// RQ15: without output override, idle bit reflects the idle pin.
// RQ16: init-complete flag rises when the rom load finishes.
// RQ17: host keeps reserved bit 4 at its default on updates.
// RQ18: a new address applies only to transactions starting after the write.
module dcr_config_regs (
   input wire logic clk, // 100 MHz system clock
   input wire logic rst_n, // power-up reset, sync, active low
   input wire dcr_pkg::dcr_req_s req, // register access from serial slave
   input wire logic xferIdle, // serial bus between transactions
   input wire logic [6:0] addressStrapPin, // strapped bus address
   input wire logic portSelPin, // input port select pin
   input wire logic driveOnPin, // output drive pin
   input wire logic idleStatePin, // idle state select pin
   input wire logic linkLock, // serial link lock
   output logic [7:0] rdData, // read data, valid cycle after rdEn
   output logic [6:0] activeAddr, // address the serial slave matches
   output dcr_pkg::dcr_ctl_s ctl, // resolved pin controls
   output logic outHiZ, // parallel outputs in high impedance
   output logic outHsZero, // parallel outputs in high-speed zero
   output logic logicReset, // reset to datapath, active high
   output logic initDone // init complete flag
);
   logic [6:0] progAddr_r;
   logic addrOvr_r;
   logic [6:0] strap_r;
   logic [4:0] rstRsvd_r;
   logic [7:0] gcfg_r;
   logic [5:0] pulseCnt_r;
   logic fullRst_r;
   logic romStart_r;
   logic romBusy;
   logic romDone;
   logic strapTaken_r;
   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   // compares an access address with an offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction
   wire wrAddr = req.wrEn && hit(req.addr, `DCR_OFS_ADDR);
   wire wrRst = req.wrEn && hit(req.addr, `DCR_OFS_RST);
   wire wrGcfg = req.wrEn && hit(req.addr, `DCR_OFS_GCFG);
   wire regRst = !rst_n || fullRst_r;
   wire ovrNxt = wrAddr ? req.data[`DCR_ADDR_OVR_BIT] : addrOvr_r;
   // address in use: strap unless override set
   wire [6:0] curAddr = addrOvr_r ? progAddr_r : strap_r; // see RQ4
   wire outOvr = gcfg_r[`DCR_GCFG_OUT_OVR_BIT];
   wire selEff = gcfg_r[`DCR_GCFG_PORT_OVR_BIT] ? gcfg_r[`DCR_GCFG_PORT_SEL_BIT] : portSelPin; // see RQ9
   wire driveEff = outOvr ? gcfg_r[`DCR_GCFG_DRIVE_BIT] : driveOnPin; // see RQ11
   wire idleEff = outOvr ? gcfg_r[`DCR_GCFG_IDLE_BIT] : idleStatePin; // see RQ11
   wire [7:0] gcfgView = {gcfg_r[7], selEff, gcfg_r[5:4], driveEff, idleEff, 2'b00}; // see RQ10
   wire [7:0] stsView = {1'b0, romDone, 6'h00};
   wire [7:0] rdMux = hit(req.addr, `DCR_OFS_ADDR) ? {curAddr, addrOvr_r} :
                      hit(req.addr, `DCR_OFS_RST) ? {rstRsvd_r, 3'b000} :
                      hit(req.addr, `DCR_OFS_GCFG) ? gcfgView :
                      hit(req.addr, `DCR_OFS_STS) ? stsView : 8'h00;
   // ---------------------------------------------
   // rom loader
   // ---------------------------------------------
   dcr_rom_loader loader (
      .clk(clk),
      .rst_n(!regRst),
      .start(romStart_r),
      .busy(romBusy),
      .done(romDone)
   );
   // ---------------------------------------------
   // strap capture and address register
   // ---------------------------------------------
   // strap caught on the first clock after reset release, not under reset
   always_ff @(posedge clk) begin
      if (regRst) begin
         strapTaken_r <= 1'b0;
         strap_r <= `DCR_ADDR_DEFAULT;
      end else if (!strapTaken_r) begin
         strapTaken_r <= 1'b1;
         strap_r <= addressStrapPin; // see RQ1
      end
   end
   // programmed address only follows writes while override is set
   always_ff @(posedge clk) begin
      if (regRst) begin
         addrOvr_r <= 1'b0;
         progAddr_r <= `DCR_ADDR_DEFAULT;
      end else if (!strapTaken_r) begin
         progAddr_r <= addressStrapPin;
      end else if (wrAddr) begin
         addrOvr_r <= req.data[`DCR_ADDR_OVR_BIT];
         if (ovrNxt) begin
            progAddr_r <= req.data[7:1]; // see RQ3
         end
      end else if (!addrOvr_r) begin
         progAddr_r <= strap_r; // see RQ2
      end
   end
   // match address only updates between transactions
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         activeAddr <= `DCR_ADDR_DEFAULT;
      end else if (xferIdle) begin
         activeAddr <= curAddr; // see RQ18
      end
   end
   // ---------------------------------------------
   // reset register with self-clearing strobes
   // ---------------------------------------------
   // strobes read back zero: they act for one cycle then clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rstRsvd_r <= 5'h00;
         fullRst_r <= 1'b0;
         romStart_r <= 1'b0;
         pulseCnt_r <= 6'h00;
         logicReset <= 1'b1;
      end else begin
         if (fullRst_r) begin
            rstRsvd_r <= 5'h00; // see RQ7
         end else if (wrRst) begin
            rstRsvd_r <= req.data[7:3];
         end
         fullRst_r <= wrRst && req.data[`DCR_RST_FULL_BIT]; // see RQ7
         romStart_r <= wrRst && req.data[`DCR_RST_ROM_BIT]; // see RQ5
         if (wrRst && (req.data[`DCR_RST_FULL_BIT] || req.data[`DCR_RST_KEEP_BIT])) begin
            pulseCnt_r <= `DCR_RESET_PULSE_CYC; // see RQ8
         end else if (pulseCnt_r != 6'h00) begin
            pulseCnt_r <= pulseCnt_r - 6'h01;
         end
         logicReset <= (pulseCnt_r != 6'h00) || romBusy;
      end
   end
   // ---------------------------------------------
   // general configuration
   // ---------------------------------------------
   // pin-driven bits are stored but read back the pin unless overridden
   always_ff @(posedge clk) begin
      if (regRst) begin
         gcfg_r <= `DCR_GCFG_RST;
      end else if (wrGcfg) begin
         gcfg_r <= {req.data[7:2], 2'b00};
      end
   end
   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   // hi-z needs idle=1 and drive=0; hs-zero applies with lock low, idle=0
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData <= 8'h00;
         ctl <= '0;
         outHiZ <= 1'b0;
         outHsZero <= 1'b0;
         initDone <= 1'b0;
      end else begin
         rdData <= req.rdEn ? rdMux : 8'h00;
         ctl <= '{portSel: selEff, driveOn: driveEff, idleState: idleEff}; // see RQ13 see RQ15
         outHiZ <= idleEff && !driveEff; // see RQ12
         outHsZero <= !linkLock && !idleEff; // see RQ14
         initDone <= romDone; // see RQ16
      end
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   property p_strap_read;
      @(posedge clk) disable iff (!rst_n)
      (req.rdEn && hit(req.addr, `DCR_OFS_ADDR) && !addrOvr_r && strapTaken_r) |=> (rdData[7:1] == strap_r);
   endproperty
   a_strap_read: assert property (p_strap_read) else $error("strapped address not read"); // see RQ2
   property p_prog_write;
      @(posedge clk) disable iff (!rst_n)
      (wrAddr && req.data[`DCR_ADDR_OVR_BIT] && strapTaken_r && !fullRst_r) |=> (curAddr == $past(req.data[7:1]));
   endproperty
   a_prog_write: assert property (p_prog_write) else $error("programmed address lost"); // see RQ3
   property p_sel;
      @(posedge clk) disable iff (!rst_n) (xferIdle && !addrOvr_r) |=> (activeAddr == $past(strap_r));
   endproperty
   a_sel: assert property (p_sel) else $error("address source wrong"); // see RQ4
   property p_rom;
      @(posedge clk) disable iff (!rst_n)
      (wrRst && req.data[`DCR_RST_ROM_BIT]) |=> ##2 (!romDone) ##[1:40] romDone;
   endproperty
   a_rom: assert property (p_rom) else $error("rom reload did not complete"); // see RQ5
   property p_full;
      @(posedge clk) disable iff (!rst_n)
      (wrRst && req.data[`DCR_RST_FULL_BIT]) |=> ##1 (gcfg_r == `DCR_GCFG_RST && !addrOvr_r && rstRsvd_r == 5'h00);
   endproperty
   a_full: assert property (p_full) else $error("full reset kept registers"); // see RQ7
   property p_keep;
      @(posedge clk) disable iff (!rst_n)
      (wrRst && req.data[`DCR_RST_KEEP_BIT] && !req.data[`DCR_RST_FULL_BIT] && !fullRst_r)
      |=> ##1 (logicReset && $stable(gcfg_r));
   endproperty
   a_keep: assert property (p_keep) else $error("logic reset wrong"); // see RQ8
   property p_hiz;
      @(posedge clk) disable iff (!rst_n) (idleEff && !driveEff) |=> outHiZ;
   endproperty
   a_hiz: assert property (p_hiz) else $error("outputs not hi-z"); // see RQ12
   property p_hs0;
      @(posedge clk) disable iff (!rst_n) (!linkLock && !idleEff) |=> outHsZero;
   endproperty
   a_hs0: assert property (p_hs0) else $error("outputs not hs-zero"); // see RQ14
   property p_pin;
      @(posedge clk) disable iff (!rst_n) (!outOvr) |=> (ctl.driveOn == $past(driveOnPin));
   endproperty
   a_pin: assert property (p_pin) else $error("drive bit not from pin"); // see RQ13
   // ---------------------------------------------
   // assertions: address and strap
   // ---------------------------------------------
   // the matched address must not move under a transaction in flight
   property p_hold;
      @(posedge clk) disable iff (!rst_n) (!xferIdle) |=> $stable(activeAddr);
   endproperty
   a_hold: assert property (p_hold) else $error("address changed mid-transaction"); // see RQ18
   property p_strap_cap;
      @(posedge clk) disable iff (!rst_n)
      (!strapTaken_r && !fullRst_r) |=> (strap_r == $past(addressStrapPin));
   endproperty
   a_strap_cap: assert property (p_strap_cap) else $error("strap not captured"); // see RQ1
   property p_addr_ro;
      @(posedge clk) disable iff (!rst_n)
      (wrAddr && !req.data[`DCR_ADDR_OVR_BIT] && strapTaken_r && !fullRst_r) |=> (curAddr == $past(strap_r));
   endproperty
   a_addr_ro: assert property (p_addr_ro) else $error("address written without override"); // see RQ2
   // ---------------------------------------------
   // assertions: reset strobes and rom load
   // ---------------------------------------------
   // a reload holds the datapath in reset for the whole load
   property p_rom_busy;
      @(posedge clk) disable iff (!rst_n) (romStart_r && !fullRst_r) |=> (romBusy && !romDone);
   endproperty
   a_rom_busy: assert property (p_rom_busy) else $error("rom reload not started"); // see RQ5
   property p_busy_rst;
      @(posedge clk) disable iff (!rst_n) romBusy |=> logicReset;
   endproperty
   a_busy_rst: assert property (p_busy_rst) else $error("datapath not held during load"); // see RQ5
   property p_init;
      @(posedge clk) disable iff (!rst_n) ($fell(romBusy) && !$past(fullRst_r)) |-> romDone ##1 initDone;
   endproperty
   a_init: assert property (p_init) else $error("init flag not raised after load"); // see RQ16
   property p_keep_len;
      @(posedge clk) disable iff (!rst_n)
      (wrRst && req.data[`DCR_RST_KEEP_BIT]) |=> ##1 logicReset [*4];
   endproperty
   a_keep_len: assert property (p_keep_len) else $error("logic reset pulse too short"); // see RQ8
   // ---------------------------------------------
   // assertions: pin or register sourced controls
   // ---------------------------------------------
   // each control follows its pin unless the override hands it to the register
   property p_port_reg;
      @(posedge clk) disable iff (!rst_n)
      gcfg_r[`DCR_GCFG_PORT_OVR_BIT] |=> (ctl.portSel == $past(gcfg_r[`DCR_GCFG_PORT_SEL_BIT]));
   endproperty
   a_port_reg: assert property (p_port_reg) else $error("port choice not from register"); // see RQ9
   property p_port_pin;
      @(posedge clk) disable iff (!rst_n)
      (!gcfg_r[`DCR_GCFG_PORT_OVR_BIT]) |=> (ctl.portSel == $past(portSelPin));
   endproperty
   a_port_pin: assert property (p_port_pin) else $error("port choice not from pin"); // see RQ10
   property p_gcfg_read;
      @(posedge clk) disable iff (!rst_n)
      (req.rdEn && hit(req.addr, `DCR_OFS_GCFG) && !gcfg_r[`DCR_GCFG_PORT_OVR_BIT])
      |=> (rdData[`DCR_GCFG_PORT_SEL_BIT] == $past(portSelPin));
   endproperty
   a_gcfg_read: assert property (p_gcfg_read) else $error("port bit does not show the pin"); // see RQ10
   property p_idle_pin;
      @(posedge clk) disable iff (!rst_n) (!outOvr) |=> (ctl.idleState == $past(idleStatePin));
   endproperty
   a_idle_pin: assert property (p_idle_pin) else $error("idle bit not from pin"); // see RQ15
   property p_drive_reg;
      @(posedge clk) disable iff (!rst_n)
      outOvr |=> ((ctl.driveOn == $past(gcfg_r[`DCR_GCFG_DRIVE_BIT]))
                 && (ctl.idleState == $past(gcfg_r[`DCR_GCFG_IDLE_BIT])));
   endproperty
   a_drive_reg: assert property (p_drive_reg) else $error("output controls not from register"); // see RQ11
   property p_hiz_off;
      @(posedge clk) disable iff (!rst_n) !(idleEff && !driveEff) |=> !outHiZ;
   endproperty
   a_hiz_off: assert property (p_hiz_off) else $error("outputs hi-z while driven"); // see RQ12
   property p_hs0_lock;
      @(posedge clk) disable iff (!rst_n) linkLock |=> !outHsZero;
   endproperty
   a_hs0_lock: assert property (p_hs0_lock) else $error("hs-zero with link locked"); // see RQ14
   // cover points: override write, reload, hi-z, full and keep resets
   c_ovr: cover property (@(posedge clk) wrAddr && req.data[`DCR_ADDR_OVR_BIT]);
   c_rom: cover property (@(posedge clk) $rose(romDone));
   c_hiz: cover property (@(posedge clk) outHiZ);
   c_full: cover property (@(posedge clk) fullRst_r);
   c_keep: cover property (@(posedge clk) wrRst && req.data[`DCR_RST_KEEP_BIT]);
endmodule

// *** dcr_host_model.sv ***
`timescale 1ns/1ps
// host controller on the far side of the register port
module dcr_host_model (
   input wire logic clk, // system clock
   input wire logic [7:0] rdData, // read data from the block
   output dcr_pkg::dcr_req_s req, // access strobe
   output logic xferIdle // high between transactions
);
   initial begin
      req = '0;
      xferIdle = 1'b1;
   end
   // ----------------------------------------
   // one access, strobe for a single cycle
   // ----------------------------------------
   // released address/data show the inverse so stale values cannot pass
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      xferIdle = 1'b0;
      req = '{wrEn: wr, rdEn: !wr, addr: a, data: d};
      @(negedge clk);
      q = rdData;
      req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, data: ~d};
      @(negedge clk);
      xferIdle = 1'b1;
   endtask
   // poll the init-complete flag with a bounded number of reads
   task automatic pollInit(output logic ok);
      logic [7:0] q;
      ok = 1'b0;
      for (int i = 0; i < 60 && !ok; i++) begin
         xfer(1'b0, 8'h04, 8'h00, q);
         ok = q[6];
      end
   endtask
endmodule

// *** deser_config_reset_regs_bench.sv ***
`timescale 1ns/1ps
`include "dcr_consts.svh"
module deser_config_reset_regs_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] strap, a;
   logic portPin, drvPin, idlPin, lock, ok;
   logic [7:0] q, w, e;
   integer seed, num_errors = 0, n_checks = 0;
   dcr_pkg::dcr_req_s req;
   dcr_pkg::dcr_ctl_s ctl;
   logic xferIdle, outHiZ, outHsZero, logicReset, initDone;
   logic [7:0] rdData;
   logic [6:0] activeAddr;
   always #5 clk = ~clk;
   dcr_host_model host (.clk(clk), .rdData(rdData), .req(req), .xferIdle(xferIdle));
   dcr_config_regs dut (.clk(clk), .rst_n(rst_n), .req(req), .xferIdle(xferIdle), .addressStrapPin(strap),
      .portSelPin(portPin), .driveOnPin(drvPin), .idleStatePin(idlPin), .linkLock(lock), .rdData(rdData),
      .activeAddr(activeAddr), .ctl(ctl), .outHiZ(outHiZ), .outHsZero(outHsZero), .logicReset(logicReset),
      .initDone(initDone));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // pin-sourced bits show the pins unless their override is set
   function automatic logic [7:0] expG(input logic [7:0] v);
      return {v[7], v[7] ? v[6] : portPin, v[5], v[4], v[5] ? v[3] : drvPin, v[5] ? v[2] : idlPin, 2'b00};
   endfunction
   task automatic rd(input logic [7:0] adr);
      host.xfer(1'b0, adr, 8'h00, q);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [7:0] t;
      host.xfer(1'b1, adr, d, t);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #300000;
      num_errors++;
      conclude;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      seed = 32'h5209;
      strap = 7'($random(seed));
      {portPin, drvPin, idlPin} = 3'($random(seed));
      lock = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      host.pollInit(ok);
      chk({7'h00, ok}, 8'h01);
      rd(`DCR_OFS_ADDR);
      chk(q, {strap, 1'b0});
      chk({1'b0, activeAddr}, {1'b0, strap});
      rd(`DCR_OFS_RST);
      chk(q, 8'h00);
      rd(`DCR_OFS_GCFG);
      chk(q, expG(`DCR_GCFG_RST));
      $display("test reset values done");
      a = 7'($random(seed));
      wr(`DCR_OFS_ADDR, {a, 1'b0});
      rd(`DCR_OFS_ADDR);
      chk(q, {strap, 1'b0});
      wr(`DCR_OFS_ADDR, {a, 1'b1});
      rd(`DCR_OFS_ADDR);
      chk(q, {a, 1'b1});
      repeat (2) @(negedge clk);
      chk({1'b0, activeAddr}, {1'b0, a});
      $display("test address done");
      // corner cases first: hi-z combination, then all overrides with hs-zero
      for (int i = 0; i < 16; i++) begin
         w = (i == 0) ? 8'h24 : (i == 1) ? 8'hE0 : 8'($random(seed));
         w[4] = 1'b1;
         {portPin, drvPin, idlPin, lock} = 4'($random(seed));
         wr(`DCR_OFS_GCFG, w);
         repeat (2) @(negedge clk);
         rd(`DCR_OFS_GCFG);
         e = expG(w);
         chk(q, e);
         chk({5'h00, ctl}, {5'h00, e[6], e[3], e[2]});
         if (!lock)
            chk({7'h00, outHiZ}, {7'h00, e[2] & !e[3]});
         chk({7'h00, outHsZero}, {7'h00, !e[2] & !lock});
      end
      $display("test general configuration done");
      wr(`DCR_OFS_GCFG, 8'hB4);
      // reserved bits set: the keep reset must leave them, the full reset must clear them
      wr(`DCR_OFS_RST, 8'hA9);
      chk({7'h00, logicReset}, 8'h01);
      repeat (8) @(negedge clk);
      chk({7'h00, logicReset}, 8'h00);
      rd(`DCR_OFS_GCFG);
      chk(q, expG(8'hB4));
      rd(`DCR_OFS_RST);
      chk(q, 8'hA8);
      $display("test keep-register reset done");
      wr(`DCR_OFS_RST, 8'hFA);
      host.pollInit(ok);
      rd(`DCR_OFS_ADDR);
      chk(q, {strap, 1'b0});
      rd(`DCR_OFS_GCFG);
      chk(q, expG(`DCR_GCFG_RST));
      rd(`DCR_OFS_RST);
      chk(q, 8'h00);
      $display("test full reset done");
      wr(`DCR_OFS_RST, 8'h04);
      repeat (3) @(negedge clk);
      chk({7'h00, initDone}, 8'h00);
      host.pollInit(ok);
      chk({7'h00, ok}, 8'h01);
      rd(`DCR_OFS_RST);
      chk(q, 8'h00);
      $display("test rom reload done");
      conclude;
   end
endmodule
